// *** dscp_pkg.sv ***
// dscp_pkg: constants shared by the serial control port files
// assumes nothing beyond a SystemVerilog compiler
package dscp_pkg;
  // register space
  localparam int          ADDR_W      = 5;
  localparam int          BYTE_W      = 8;
  localparam int          NUM_REGS    = 32;
  localparam logic [4:0]  CFG_ADDR    = 5'h00;
  localparam logic [4:0]  ADDR_STEP   = 5'h01;
  // configuration register bit positions
  localparam int          BIT_BIDIR   = 7;
  localparam int          BIT_LSB     = 6;
  localparam int          BIT_SRST    = 5;
  // instruction byte fields
  localparam int          INSTR_RW    = 7;
  localparam int          INSTR_N_HI  = 6;
  localparam int          INSTR_N_LO  = 5;
  localparam int          INSTR_A_HI  = 4;
  // bit counter and byte count values
  localparam logic [2:0]  BIT_FIRST   = 3'h0;
  localparam logic [2:0]  BIT_LAST    = 3'h7;
  localparam logic [2:0]  BIT_STEP    = 3'h1;
  localparam logic [1:0]  CNT_ZERO    = 2'h0;
  localparam logic [1:0]  CNT_STEP    = 2'h1;
  // host serial clock ceiling, MHz, and settling bound in reference cycles
  localparam int          SCLK_MAX_MHZ  = 15;
  localparam int          SETTLE_REF_CYC = 200;
  // synchroniser depth
  localparam int          SYNC_STAGES = 2;
  // port sequencer states, one-hot
  typedef enum logic [3:0]
  {
    DSCP_INSTR = 4'h1,
    DSCP_WRITE = 4'h2,
    DSCP_READ  = 4'h4,
    DSCP_DONE  = 4'h8
  } dscp_state_t;
endpackage : dscp_pkg

// *** dscp_sync.sv ***
// dscp_sync: two-flop synchronisers for a group of pin inputs
// assumes the pins are asynchronous to clk; outputs are stage two only
`timescale 1ns/1ps
module dscp_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // pins in, synchronised copies out
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);
  // one chain per pin; first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_chain
      logic [dscp_pkg::SYNC_STAGES-1:0] stage_reg;
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          stage_reg <= '0;
        else
          stage_reg <= {stage_reg[dscp_pkg::SYNC_STAGES-2:0], pin_in[i]};
      end
      assign pin_sync[i] = stage_reg[dscp_pkg::SYNC_STAGES-1];
    end
  endgenerate
endmodule : dscp_sync

// *** dscp_port.sv ***
// dscp_port: serial control port and 32 x 8 configuration register file
// assumes host serial clock well below clk/2 (host limit 15 MHz vs 50 MHz clk);
// the pins are oversampled through dscp_sync and edges found in clk domain
`timescale 1ns/1ps
module dscp_port #(
  parameter int                                         NUM_REGS = dscp_pkg::NUM_REGS,
  parameter logic [dscp_pkg::NUM_REGS*dscp_pkg::BYTE_W-1:0] REG_DEFAULTS = '0
) (
  // clock and reset
  input  wire logic                                     clk,
  input  wire logic                                     rst_n,
  // serial pins from the host
  input  wire logic                                     serial_clk_pin,
  input  wire logic                                     port_select_n,
  input  wire logic                                     serial_data_io_in,
  // bidirectional data pin, drive side
  output logic                                          serial_data_io_out,
  output logic                                          serial_data_io_oe,
  // dedicated output data pin
  output logic                                          serial_data_out_pin,
  output logic                                          serial_data_out_oe,
  // register contents to the converter core, register n at bits 8n+7..8n
  output logic [dscp_pkg::NUM_REGS*dscp_pkg::BYTE_W-1:0] config_regs,
  // one-cycle request to reload the reference_clock_input multiplier
  output logic                                          mult_reload
);

  // synchronised pins
  logic [2:0] pin_sync;
  logic       sclk_s;
  logic       sel_n_s;
  logic       sdi_s;

  // pins cross into clk before anything reads them; select enters inverted
  // so the cleared chain reads as deselected after reset, not as a live cycle
  dscp_sync #(
    .WIDTH    (3)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .pin_in   ({serial_clk_pin, ~port_select_n, serial_data_io_in}),
    .pin_sync (pin_sync)
  );

  assign sclk_s  = pin_sync[2];
  assign sel_n_s = ~pin_sync[1];
  assign sdi_s   = pin_sync[0];

  // state
  logic [dscp_pkg::BYTE_W-1:0] regs_reg [NUM_REGS];
  dscp_pkg::dscp_state_t       state_reg;
  dscp_pkg::dscp_state_t       state_next;
  logic                        sclk_d_reg;
  logic [dscp_pkg::BYTE_W-1:0] rx_reg;
  logic [2:0]                  bit_cnt_reg;
  logic [dscp_pkg::ADDR_W-1:0] addr_reg;
  logic [1:0]                  left_reg;
  logic [dscp_pkg::BYTE_W-1:0] tx_reg;
  logic [2:0]                  tx_idx_reg;
  logic                        out_bit_reg;
  logic                        io_oe_reg;
  logic                        out_oe_reg;
  logic                        recovered_reg;
  logic                        reload_reg;

  // pattern with bits 3..0 mirroring bits 4..7 and reset bit high or low
  function automatic logic dscp_mirror_ok(input logic [dscp_pkg::BYTE_W-1:0] b);
    dscp_mirror_ok = (b[0] == b[7]) && (b[1] == b[6]) && (b[2] == b[5]) &&
                     (b[3] == b[4]);
  endfunction : dscp_mirror_ok

  // configuration bits read live from register zero
  wire cfg_bidir = regs_reg[dscp_pkg::CFG_ADDR][dscp_pkg::BIT_BIDIR];
  wire cfg_lsb   = regs_reg[dscp_pkg::CFG_ADDR][dscp_pkg::BIT_LSB];

  // edge detection on the synchronised clock; gated by select
  wire sel_active = ~sel_n_s;
  wire sclk_rise  = sel_active & sclk_s & ~sclk_d_reg;
  wire sclk_fall  = sel_active & ~sclk_s & sclk_d_reg;

  // next shift value in the selected order
  wire [dscp_pkg::BYTE_W-1:0] rx_next = cfg_lsb ?
                                        {sdi_s, rx_reg[dscp_pkg::BYTE_W-1:1]} :
                                        {rx_reg[dscp_pkg::BYTE_W-2:0], sdi_s};
  wire byte_done = sclk_rise && (bit_cnt_reg == dscp_pkg::BIT_LAST);

  // instruction decode
  wire                        instr_rd   = rx_next[dscp_pkg::INSTR_RW];
  wire [1:0]                  instr_cnt  = rx_next[dscp_pkg::INSTR_N_HI:dscp_pkg::INSTR_N_LO];
  wire [dscp_pkg::ADDR_W-1:0] instr_addr = rx_next[dscp_pkg::INSTR_A_HI:0];

  // address stepping wraps in five bits by width alone
  wire [dscp_pkg::ADDR_W-1:0] addr_step = cfg_lsb ? addr_reg + dscp_pkg::ADDR_STEP :
                                                     addr_reg - dscp_pkg::ADDR_STEP;

  // write decode
  wire wr_byte   = byte_done && (state_reg == dscp_pkg::DSCP_WRITE);
  wire wr_cfg    = wr_byte && (addr_reg == dscp_pkg::CFG_ADDR);
  wire srst_hit  = wr_cfg && rx_next[dscp_pkg::BIT_SRST];
  wire recov_hit = srst_hit && dscp_mirror_ok(rx_next);
  wire reload_hit = wr_cfg && !rx_next[dscp_pkg::BIT_SRST] &&
                    dscp_mirror_ok(rx_next) && recovered_reg;
  wire last_byte = (left_reg == dscp_pkg::CNT_ZERO);

  // read bit selection in the live order
  wire [2:0] tx_pos = cfg_lsb ? tx_idx_reg : (dscp_pkg::BIT_LAST - tx_idx_reg);
  wire [dscp_pkg::ADDR_W-1:0] rd_addr = (state_reg == dscp_pkg::DSCP_INSTR) ?
                                        instr_addr : addr_step;

  // sequencer next state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      dscp_pkg::DSCP_INSTR:
      begin
        if (byte_done)
          state_next = instr_rd ? dscp_pkg::DSCP_READ : dscp_pkg::DSCP_WRITE;
      end
      dscp_pkg::DSCP_WRITE,
      dscp_pkg::DSCP_READ:
      begin
        if (byte_done && last_byte)
          state_next = dscp_pkg::DSCP_DONE;
      end
      dscp_pkg::DSCP_DONE:
        state_next = dscp_pkg::DSCP_DONE;
      default:
        state_next = dscp_pkg::DSCP_INSTR;
    endcase
  end

  // sequencer state; select high parks it at instruction phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= dscp_pkg::DSCP_INSTR;
    else if (!sel_active)
      state_reg <= dscp_pkg::DSCP_INSTR;
    else
      state_reg <= state_next;
  end

  // edge history of the synchronised clock
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sclk_d_reg <= 1'b0;
    else
      sclk_d_reg <= sclk_s;
  end

  // receive shifter and bit counter; partial byte dropped on deselect
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_reg      <= '0;
      bit_cnt_reg <= dscp_pkg::BIT_FIRST;
    end
    else if (!sel_active)
    begin
      rx_reg      <= '0;
      bit_cnt_reg <= dscp_pkg::BIT_FIRST;
    end
    else if (sclk_rise)
    begin
      rx_reg      <= rx_next;
      bit_cnt_reg <= bit_cnt_reg + dscp_pkg::BIT_STEP;
    end
  end

  // address and remaining byte count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_reg <= '0;
      left_reg <= dscp_pkg::CNT_ZERO;
    end
    else if (byte_done && (state_reg == dscp_pkg::DSCP_INSTR))
    begin
      addr_reg <= instr_addr;
      left_reg <= instr_cnt;
    end
    else if (byte_done && !last_byte)
    begin
      addr_reg <= addr_step;
      left_reg <= left_reg - dscp_pkg::CNT_STEP;
    end
  end

  // register file; each byte lands on its own last bit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int r = 0; r < NUM_REGS; r++)
        regs_reg[r] <= REG_DEFAULTS[r*dscp_pkg::BYTE_W +: dscp_pkg::BYTE_W];
    end
    else if (srst_hit)
    begin
      // register zero keeps the written byte, the rest go to defaults
      for (int r = 1; r < NUM_REGS; r++)
        regs_reg[r] <= REG_DEFAULTS[r*dscp_pkg::BYTE_W +: dscp_pkg::BYTE_W];
      regs_reg[dscp_pkg::CFG_ADDR] <= rx_next;
    end
    else if (wr_byte)
      regs_reg[addr_reg] <= rx_next;
  end

  // recovery flag arms the multiplier reload on the following write to register zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      recovered_reg <= 1'b0;
      reload_reg    <= 1'b0;
    end
    else
    begin
      reload_reg <= reload_hit;
      if (recov_hit)
        recovered_reg <= 1'b1;
      else if (wr_cfg)
        recovered_reg <= 1'b0;
    end
  end

  // read byte and bit position; next byte fetched as the current one ends
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_reg     <= '0;
      tx_idx_reg <= dscp_pkg::BIT_FIRST;
    end
    else if (byte_done && (state_next == dscp_pkg::DSCP_READ))
    begin
      tx_reg     <= regs_reg[rd_addr];
      tx_idx_reg <= dscp_pkg::BIT_FIRST;
    end
    else if (sclk_fall && (state_reg == dscp_pkg::DSCP_READ))
      tx_idx_reg <= tx_idx_reg + dscp_pkg::BIT_STEP;
  end

  // outgoing bit changes only on falling edges; order read live so a
  // mid-cycle order change shows on the very next bit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      out_bit_reg <= 1'b0;
    else if (sclk_fall && (state_reg == dscp_pkg::DSCP_READ))
      out_bit_reg <= tx_reg[tx_pos];
  end

  // output enables; released whenever select is high or not reading
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_oe_reg  <= 1'b0;
      out_oe_reg <= 1'b0;
    end
    else
    begin
      io_oe_reg  <= sel_active && (state_reg == dscp_pkg::DSCP_READ) && cfg_bidir;
      out_oe_reg <= sel_active && (state_reg == dscp_pkg::DSCP_READ) && !cfg_bidir;
    end
  end

  // flatten the register file for the converter core
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++)
    begin : g_flat
      assign config_regs[g*dscp_pkg::BYTE_W +: dscp_pkg::BYTE_W] = regs_reg[g];
    end
  endgenerate

  // outputs straight from flops
  assign serial_data_io_out  = out_bit_reg;
  assign serial_data_io_oe   = io_oe_reg;
  assign serial_data_out_pin = out_bit_reg;
  assign serial_data_out_oe  = out_oe_reg;
  assign mult_reload         = reload_reg;

endmodule : dscp_port

// *** dscp_port_assertions.sv ***
// dscp_port_assertions: pin-level checks on the serial control port
// assumes it is bound into dscp_port and that the host clock is far below clk
`timescale 1ns/1ps
module dscp_chk #(
  parameter logic [255:0] REG_DEFAULTS = '0
) (
  // clock and reset
  input wire logic         clk,
  input wire logic         rst_n,
  // host pins
  input wire logic         serial_clk_pin,
  input wire logic         port_select_n,
  // data outputs
  input wire logic         serial_data_io_oe,
  input wire logic         serial_data_out_pin,
  input wire logic         serial_data_out_oe,
  // register file and reload request
  input wire logic [255:0] config_regs,
  input wire logic         mult_reload
);
  // register zero; the pins pass two sync flops, hence the lags below
  wire [7:0] cfg = config_regs[7:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_deselected;
    port_select_n [*6];
  endsequence
  sequence s_bit_moves;
    serial_data_out_oe && $past(serial_data_out_oe) && $changed(serial_data_out_pin);
  endsequence
  a_pins_released: assert property (s_deselected |-> !serial_data_io_oe && !serial_data_out_oe)
    else $error("data pin driven while deselected");
  a_sdo_one_pin: assert property (serial_data_out_oe |-> !cfg[7])
    else $error("dedicated output driven in one-pin mode");
  a_sdio_mode: assert property (serial_data_io_oe |-> cfg[7])
    else $error("shared pin driven in two-wire mode");
  a_data_on_fall: assert property (s_bit_moves |-> !$past(serial_clk_pin, 2))
    else $error("read bit changed while serial clock high");
  a_oe_in_cycle: assert property ($rose(serial_data_out_oe || serial_data_io_oe)
    |-> !port_select_n && !$past(port_select_n, 4))
    else $error("read drive started outside a cycle");
  a_regs_gated: assert property ($changed(config_regs) |-> !$past(port_select_n, 3))
    else $error("register changed with select high");
  a_srst_clears: assert property ($rose(cfg[5]) |-> ##[0:1] config_regs[255:8] == REG_DEFAULTS[255:8])
    else $error("soft reset left a register set");
  a_reload_pulse: assert property (mult_reload |=> !mult_reload)
    else $error("reload longer than one cycle");
  a_reload_shape: assert property (mult_reload |-> ##[0:1] (cfg[5:2] == 4'h0 && cfg[1] == cfg[6]
    && cfg[0] == cfg[7]))
    else $error("reload without mirrored pattern");
endmodule : dscp_chk

bind dscp_port dscp_chk #(.REG_DEFAULTS(REG_DEFAULTS)) i_chk (
  .clk(clk), .rst_n(rst_n), .serial_clk_pin(serial_clk_pin), .port_select_n(port_select_n),
  .serial_data_io_oe(serial_data_io_oe), .serial_data_out_pin(serial_data_out_pin),
  .serial_data_out_oe(serial_data_out_oe), .config_regs(config_regs), .mult_reload(mult_reload)
);

// *** dscp_host.sv ***
// dscp_host: behavioural host driving the serial control port pins
// assumes the bench resolves the shared data line with a pull-up
`timescale 1ns/1ps
module dscp_host (
  // pins driven by the host
  output logic      serial_clk_pin,
  output logic      port_select_n,
  output logic      host_data,
  output logic      host_data_oe,
  // resolved lines seen by the host
  input  wire logic sdio_line,
  input  wire logic sdo_line
);
  // long low phase lets the synchronised read bit settle before the rise
  localparam int T_LO = 100;
  localparam int T_HI = 60; // 160 ns period, below 15 MHz
  // clock idles low outside frames
  initial
  begin
    serial_clk_pin = 1'b0;
    port_select_n  = 1'b1;
    host_data      = 1'b0;
    host_data_oe   = 1'b0;
  end
  task automatic open_frame();
    port_select_n = 1'b0; // low until close_frame
    #(T_LO);
  endtask : open_frame
  task automatic close_frame();
    #(T_LO);
    port_select_n = 1'b1;
    host_data_oe  = 1'b0;
    #(2*T_LO);
  endtask : close_frame
  // n bits of one byte; data moves only while the clock is low
  task automatic xfer(input logic [7:0] w, input bit lsb, input bit rd, input bit pin2,
                      input int n, output logic [7:0] r);
    int i;
    int b;
    r = 8'h00;
    for (i = 0; i < n; i++)
    begin
      b = lsb ? i : 7 - i;
      serial_clk_pin = 1'b0;
      host_data_oe   = !rd;
      host_data      = w[b];
      #(T_LO);
      serial_clk_pin = 1'b1;
      r[b] = pin2 ? sdo_line : sdio_line;
      #(T_HI);
    end
    serial_clk_pin = 1'b0;
  endtask : xfer
endmodule : dscp_host

// *** dscp_tb.sv ***
// tb: self-checking bench for the serial control port and its host model
// assumes dscp_pkg, dscp_port, dscp_host and the checker are compiled first
`timescale 1ns/1ps
module tb;
  logic         clk;
  logic         rst_n;
  logic         sclk;
  logic         sel_n;
  logic         host_d;
  logic         host_oe;
  logic         io_out;
  logic         io_oe;
  logic         so;
  logic         so_oe;
  logic         reload;
  logic [255:0] regs;
  int           n_fail    = 0;
  int           cmp_count = 0;
  int           n_reload  = 0;
  // pulled-up lines; two drivers at once read as unknown
  wire sdio = io_oe ? (host_oe ? 1'bX : io_out) : (host_oe ? host_d : 1'b1);
  wire sdo  = so_oe ? so : 1'b1;
  dscp_port i_dut (
    .clk(clk), .rst_n(rst_n), .serial_clk_pin(sclk), .port_select_n(sel_n),
    .serial_data_io_in(sdio), .serial_data_io_out(io_out), .serial_data_io_oe(io_oe),
    .serial_data_out_pin(so), .serial_data_out_oe(so_oe), .config_regs(regs), .mult_reload(reload)
  );
  dscp_host i_host (
    .serial_clk_pin(sclk), .port_select_n(sel_n), .host_data(host_d), .host_data_oe(host_oe),
    .sdio_line(sdio), .sdo_line(sdo)
  );
  // clock and reload pulse counter
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk)
    if (reload === 1'b1)
      n_reload++;
  function automatic logic [7:0] rg(input int a);
    return regs[8*a+:8];
  endfunction : rg
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // whole frame; data byte k sits at bits 8k+7..8k, count from instruction bits 6..5
  task automatic frame(input logic [7:0] ins, input logic [31:0] dat, input bit lsb,
                       input bit pin2, output logic [31:0] rd);
    logic [7:0] r;
    int k;
    rd = 32'h0;
    i_host.open_frame();
    i_host.xfer(ins, lsb, 1'b0, pin2, 8, r);
    for (k = 0; k <= int'(ins[6:5]); k++)
    begin
      i_host.xfer(dat[8*k+:8], lsb, ins[7], pin2, 8, r);
      rd[8*k+:8] = r;
    end
    i_host.close_frame();
  endtask : frame
  task automatic t_reset();
    chk(rg(0), 8'h00, "cfg default");
    chk({6'h0, io_oe, so_oe}, 8'h00, "pins idle");
    $display("test reset done");
  endtask : t_reset
  task automatic t_msb();
    logic [31:0] rd;
    frame(8'h22, 32'h0000B45A, 1'b0, 1'b1, rd);
    chk(rg(2), 8'h5A, "first byte");
    chk(rg(1), 8'hB4, "address down");
    frame(8'h41, 32'h0096003C, 1'b0, 1'b1, rd);
    chk(rg(31), 8'h96, "wrap below zero");
    frame(8'hE2, 32'h0, 1'b0, 1'b1, rd);
    chk(rd[7:0], 8'h5A, "read byte one");
    chk(rd[15:8], 8'h3C, "read byte two");
    chk(rd[23:16], 8'h00, "read byte three");
    chk(rd[31:24], 8'h96, "read wrap byte four");
    $display("test msb done");
  endtask : t_msb
  task automatic t_gate();
    logic [7:0] r;
    logic [31:0] rd;
    i_host.xfer(8'h05, 1'b0, 1'b0, 1'b1, 8, r);
    i_host.xfer(8'hFF, 1'b0, 1'b0, 1'b1, 8, r);
    i_host.open_frame();
    i_host.xfer(8'h05, 1'b0, 1'b0, 1'b1, 8, r);
    i_host.xfer(8'hFF, 1'b0, 1'b0, 1'b1, 4, r);
    i_host.close_frame();
    chk(rg(5), 8'h00, "ignored and partial");
    frame(8'h05, 32'h00000081, 1'b0, 1'b1, rd);
    chk(rg(5), 8'h81, "restart");
    $display("test gate done");
  endtask : t_gate
  task automatic t_lsb();
    logic [31:0] rd;
    frame(8'h00, 32'h000000C0, 1'b0, 1'b1, rd);
    chk(rg(0), 8'hC0, "cfg written");
    frame(8'hA1, 32'h0, 1'b1, 1'b0, rd);
    chk(rd[7:0], 8'h3C, "lsb read one");
    chk(rd[15:8], 8'h5A, "lsb read two");
    frame(8'h23, 32'h0000E10F, 1'b1, 1'b0, rd);
    chk(rg(3), 8'h0F, "lsb write one");
    chk(rg(4), 8'hE1, "address up");
    $display("test lsb done");
  endtask : t_lsb
  task automatic t_srst();
    logic [31:0] rd;
    frame(8'h00, 32'h000000E7, 1'b1, 1'b0, rd);
    chk(rg(0), 8'hE7, "cfg kept");
    chk(rg(4) | rg(5) | rg(31), 8'h00, "others defaulted");
    frame(8'h00, 32'h000000C3, 1'b1, 1'b0, rd);
    chk(8'(n_reload), 8'h01, "reload once");
    frame(8'h00, 32'h000000C3, 1'b1, 1'b0, rd);
    chk(8'(n_reload), 8'h01, "no reload unarmed");
    $display("test srst done");
  endtask : t_srst
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    t_reset();
    t_msb();
    t_gate();
    t_lsb();
    t_srst();
    summarize();
  end
  // tests need about 45 us; 1 ms means a hang
  initial
  begin
    #1000000;
    n_fail++;
    $display("BAD t=%0t watchdog expired", $time);
    summarize();
  end
endmodule : tb
